/* verilog/usb_control_token_regs.sv */
// Purpose: control, address, frame, token and config registers of usb block
// Assumes: wishbone classic slave, one clock core_clk at 10 MHz
// Notes:   line levels arrive from pins and pass three flip-flops, then a level register
// Notes on behaviour
// - control bit 6 reads live single-ended zero, both lines low
// - control bit 7 reads live J state flag, read only
// - device mode: setup token sets hold bit; hold stops token processing
// - host mode: bit 5 reads token in progress instead
// - bus reset bit drives reset signalling while 1
// - host enable bit; any change resets host control logic
// - host mode: clearing resume appends a low speed end of packet
// - address bit 7 selects low speed for the next token
// - address low seven bits hold device address, zero after reset
// - frame low byte read only, captured on each start of frame while running
// - frame upper three bits captured together with low byte
// - token upper nibble selects setup, in or out
// - config bit 7 enables eye pattern test
// - config bit 6 lets the output enable monitor signal follow drive
// - config bit 4 halts the block in chip idle mode
// - config bit 0 suspends on sleep, else suspend bit stops usb clock
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
module usb_control_token_regs
   import usb_ctl_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        dPlusIn,
   input  wire logic        dMinusIn,
   input  wire logic        setupSeen,
   input  wire logic        sofSeen,
   input  wire logic [10:0] sofFrame,
   input  wire logic        tokenDone,
   input  wire logic        lineDriving,
   input  wire logic        chipIdle,
   input  wire logic        chipSleep,
   output logic             tokenStart,
   output logic [3:0]       tokenPid,
   output logic [3:0]       tokenEndpoint,
   output logic             tokenLowSpeed,
   output logic             busResetDrive,
   output logic             resumeDrive,
   output logic             lowSpeedEop,
   output logic             hostLogicReset,
   output logic             eyeTestEnable,
   output logic             outputEnableMon_n,
   output logic             processingEnable,
   output logic             usbClockStop
);
   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic [1:0] pinRaw;
   wire  [1:0] pinLevel;
   logic       dpLevel;
   logic       dmLevel;

   // bit 0 carries the plus line, bit 1 the minus line
   assign pinRaw  = {dMinusIn, dPlusIn};
   assign dpLevel = pinLevel[0];
   assign dmLevel = pinLevel[1];

   // three stages per line; the level moves once stages two and three agree
   // only stage two reads stage one, so a metastable first stage never
   // reaches the line decode
   for (genvar g = 0; g < 2; g++) begin : g_sync
      logic [2:0] stage;
      logic       level;

      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            stage <= 3'h0;
            level <= 1'b0;
         end else begin
            stage <= {stage[1:0], pinRaw[g]};
            if (stage[1] == stage[2]) level <= stage[2];
         end
      end

      assign pinLevel[g] = level;
   end

   // line state from the settled levels; j is the full speed idle state
   wire seZero  = !dpLevel && !dmLevel;
   wire jLevel  = dpLevel && !dmLevel;

   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------
   // register map, byte 0 of each word only, upper bytes read 0:
   //   0x00 control : 7 j level, 6 single ended zero, 5 hold or busy,
   //                  4 bus reset, 3 host enable, 2 resume
   //   0x04 address : 7 low speed next token, 6-0 function address
   //   0x08 frame lo: frame number bits 7-0, read only
   //   0x0C frame hi: frame number bits 10-8, read only
   //   0x10 token   : 7-4 token code, 3-0 endpoint
   //   0x14 config  : 7 eye test, 6 oe monitor, 4 idle stop, 0 auto suspend
   //   0x18 suspend : 0 suspend request, stops the usb clock
   // unmapped words read 0 and ignore writes

   // byte address match, shared by write strobes and read decode
   function automatic logic regHit(input logic [7:0] adr,
                                   input logic [7:0] off);
      return adr == off;
   endfunction

   // a request is taken once per strobe: the ack it raises masks it
   wire req     = cyc_i && stb_i && !ack_o;
   // only the low byte lane holds bits, so writes need it
   wire wrLow   = req && we_i && sel_i[0];
   wire hitCtl  = regHit(adr_i, OFF_CONTROL);
   wire hitAdr  = regHit(adr_i, OFF_ADDRESS);
   wire hitFrl  = regHit(adr_i, OFF_FRAME_LO);
   wire hitFrh  = regHit(adr_i, OFF_FRAME_HI);
   wire hitTok  = regHit(adr_i, OFF_TOKEN);
   wire hitCfg  = regHit(adr_i, OFF_CONFIG);
   wire hitSus  = regHit(adr_i, OFF_SUSPEND);
   // write strobes, one per writable word
   wire wrCtl   = wrLow && hitCtl;
   wire wrAdr   = wrLow && hitAdr;
   wire wrTok   = wrLow && hitTok;
   wire wrCfg   = wrLow && hitCfg;
   wire wrSus   = wrLow && hitSus;

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   // software visible state
   logic       hold;
   logic       busReset;
   logic       hostEnable;
   logic       resume;
   logic [7:0] address;
   logic [7:0] frameLow;
   logic [2:0] frameHigh;
   logic [7:0] token;
   logic [7:0] config1;
   logic       suspendReq;
   logic       tokenBusy;
   resume_state_t resState;
   resume_state_t next_resState;
   logic [1:0] eopCount;

   // the host role is the enable bit itself, named for readability
   wire hostMode   = hostEnable;
   wire newHostEn  = wrCtl ? dat_i[BIT_HOST_EN] : hostEnable;
   wire hostToggle = wrCtl && (dat_i[BIT_HOST_EN] != hostEnable);
   // power gating: idle stop, sleep with auto suspend, or the suspend bit
   wire idleHalt   = config1[BIT_IDLE_STOP] && chipIdle;
   wire autoSusp   = config1[BIT_AUTO_SUSP] && chipSleep;
   wire running    = !idleHalt && !autoSusp && !suspendReq;

   // control bits written by software
   // resume and bus reset are plain levels, their timing is software's
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busReset   <= 1'b0;
         hostEnable <= 1'b0;
         resume     <= 1'b0;
      end else if (wrCtl) begin
         busReset   <= dat_i[BIT_BUS_RESET];
         hostEnable <= dat_i[BIT_HOST_EN];
         resume     <= dat_i[BIT_RESUME];
      end
   end

   // hold flag: setup event wins over a software clear
   // software moves it only in device mode; in host mode the bit reads busy
   // a setup is dropped in host mode unless the host enable is being written to 0, and while it is being written to 1
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hold <= 1'b0;
      end else if (!newHostEn && setupSeen && running) begin
         hold <= 1'b1;
      end else if (wrCtl && !hostMode) begin
         hold <= dat_i[BIT_HOLD];
      end
   end

   // address and config
   // config keeps its four implemented bits; suspend has its own word
   // bit 7 of address doubles as the low speed choice for tokens
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         address    <= RESET_BYTE;
         config1    <= RESET_BYTE;
         suspendReq <= 1'b0;
      end else begin
         if (wrAdr) address <= dat_i[7:0];
         if (wrCfg) config1 <= dat_i[7:0] & 8'hD1;
         if (wrSus) suspendReq <= dat_i[0];
      end
   end

   // frame number captured as one word on start of frame
   // both halves load at one edge, so the two registers never hold a torn number
   // a halted block keeps the last frame number
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         frameLow  <= RESET_BYTE;
         frameHigh <= 3'h0;
      end else if (sofSeen && running) begin
         frameLow  <= sofFrame[7:0];
         frameHigh <= sofFrame[10:8];
      end
   end

   // token handshake with the engine:
   //   host mode write    -> tokenStart for one cycle, busy set at once
   //   tokenDone pulse    -> busy clears, software may write the next token
   //   host enable change -> busy clears and no start is issued
   // token register and busy flag; completion clears, host toggle resets
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         token     <= RESET_BYTE;
         tokenBusy <= 1'b0;
      end else begin
         if (wrTok) token <= dat_i[7:0];
         if (hostToggle) begin
            tokenBusy <= 1'b0;
         end else if (wrTok && hostMode && running) begin
            tokenBusy <= 1'b1;
         end else if (tokenDone) begin
            tokenBusy <= 1'b0;
         end
      end
   end

   // start pulse to the token engine, data from flip-flops
   // a token written while halted is kept but never started
   // pid, endpoint and speed stand until the next token write
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tokenStart    <= 1'b0;
         tokenPid      <= 4'h0;
         tokenEndpoint <= 4'h0;
         tokenLowSpeed <= 1'b0;
      end else begin
         tokenStart <= wrTok && hostMode && running && !hostToggle;
         if (wrTok) begin
            tokenPid      <= dat_i[7:4];
            tokenEndpoint <= dat_i[3:0];
            tokenLowSpeed <= address[BIT_LOW_SPEED];
         end
      end
   end

   // ------------------------------------------------------------------
   // resume sequencer
   // ------------------------------------------------------------------
   // idle -> drive while the resume bit is set -> end of packet for
   // EOP_CYCLES cycles in host mode -> idle; device mode skips the eop.
   // the resume length itself is timed by software, not by this block
   // the state codes are gray except on the return from eop to idle
   always_comb begin
      next_resState = resState;
      case (resState)
         RES_IDLE: begin
            if (resume) next_resState = RES_DRIVE;
         end
         RES_DRIVE: begin
            if (!resume && hostMode) next_resState = RES_EOP;
            else if (!resume) next_resState = RES_IDLE;
         end
         RES_EOP: begin
            if (eopCount == EOP_CYCLES - 2'h1) next_resState = RES_IDLE;
         end
         default: next_resState = RES_IDLE;
      endcase
   end

   // state and eop counter; a host enable change drops back to idle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         resState <= RES_IDLE;
         eopCount <= 2'h0;
      end else if (hostToggle) begin
         resState <= RES_IDLE;
         eopCount <= 2'h0;
      end else begin
         resState <= next_resState;
         eopCount <= (resState == RES_EOP) ? eopCount + 2'h1 : 2'h0;
      end
   end

   // ------------------------------------------------------------------
   // outputs to the line and power logic
   // ------------------------------------------------------------------
   // every line and power output is registered, so no decode glitch
   // outputEnableMon_n is active low and rests high
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busResetDrive     <= 1'b0;
         resumeDrive       <= 1'b0;
         lowSpeedEop       <= 1'b0;
         hostLogicReset    <= 1'b0;
         eyeTestEnable     <= 1'b0;
         outputEnableMon_n <= 1'b1;
         processingEnable  <= 1'b0;
         usbClockStop      <= 1'b0;
      end else begin
         busResetDrive  <= busReset;
         resumeDrive    <= (resState == RES_DRIVE);
         lowSpeedEop    <= (resState == RES_EOP);
         hostLogicReset <= hostToggle;
         eyeTestEnable  <= config1[BIT_EYE];
         outputEnableMon_n <= !(config1[BIT_OE_MON] && lineDriving);
         processingEnable  <= running && (hostMode || !hold);
         usbClockStop   <= suspendReq || autoSusp;
      end
   end

   // ------------------------------------------------------------------
   // read mux and ack
   // ------------------------------------------------------------------
   wire [7:0] ctlRead = {jLevel, seZero,
                         hostMode ? tokenBusy : hold,
                         busReset, hostEnable, resume, 2'h0};

   // read decode, one register per word, unmapped words read zero
   logic [7:0] readByte;

   always_comb begin
      readByte = 8'h00;
      if (hitCtl) begin
         readByte = ctlRead;
      end else if (hitAdr) begin
         readByte = address;
      end else if (hitFrl) begin
         readByte = frameLow;
      end else if (hitFrh) begin
         readByte = {5'h00, frameHigh};
      end else if (hitTok) begin
         readByte = token;
      end else if (hitCfg) begin
         readByte = config1;
      end else if (hitSus) begin
         readByte = {7'h00, suspendReq};
      end
   end

   // one wait-free answer: ack one cycle after the request is seen
   // writes land at the edge that raises ack; read data stands with it
   // a read of an unmapped word still answers, with zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req;
         if (req && !we_i) dat_o <= {24'h000000, readByte};
      end
   end

   // ------------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------------
   // the eop counter needs at least one cycle to count
   if (EOP_CYCLES == 2'h0) begin : g_bad_eop
      $error("end of packet length must be at least one cycle");
   end
   // the read and write decode only serves fields inside byte 0
   if (BIT_J_LEVEL > 7 || BIT_LOW_SPEED > 7 || BIT_EYE > 7 ||
       BIT_OE_MON > 7 || BIT_IDLE_STOP > 7) begin : g_bad_field
      $error("field positions must lie in the low byte");
   end
endmodule

/* common/usb_ctl_pkg.sv */
// Purpose: shared constants for the usb control and token register block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   offsets are word aligned
package usb_ctl_pkg;
   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFF_CONTROL  = 8'h00;
   localparam logic [7:0] OFF_ADDRESS  = 8'h04;
   localparam logic [7:0] OFF_FRAME_LO = 8'h08;
   localparam logic [7:0] OFF_FRAME_HI = 8'h0C;
   localparam logic [7:0] OFF_TOKEN    = 8'h10;
   localparam logic [7:0] OFF_CONFIG   = 8'h14;
   localparam logic [7:0] OFF_SUSPEND  = 8'h18;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int BIT_J_LEVEL   = 7;
   localparam int BIT_SE0       = 6;
   localparam int BIT_HOLD      = 5;
   localparam int BIT_BUS_RESET = 4;
   localparam int BIT_HOST_EN   = 3;
   localparam int BIT_RESUME    = 2;
   localparam int BIT_LOW_SPEED = 7;
   localparam int BIT_EYE       = 7;
   localparam int BIT_OE_MON    = 6;
   localparam int BIT_IDLE_STOP = 4;
   localparam int BIT_AUTO_SUSP = 0;

   // ------------------------------------------------------------------
   // token codes and reset values
   // ------------------------------------------------------------------
   localparam logic [3:0] PID_SETUP = 4'hD;
   localparam logic [3:0] PID_IN    = 4'h9;
   localparam logic [3:0] PID_OUT   = 4'h1;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] EOP_CYCLES = 2'h2;

   typedef enum logic [1:0] {
      RES_IDLE = 2'b00,
      RES_DRIVE = 2'b01,
      RES_EOP  = 2'b11
   } resume_state_t;
endpackage

/* dv/usb_control_token_regs_chk.sv */
// Purpose: port assertions for the usb control register block
// Assumes: one clock domain, async active high reset
// Notes:   bound to the design top
`timescale 1ns/1ns
module usb_control_token_regs_chk
   import usb_ctl_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic        ack_o,
   input wire logic        lineDriving,
   input wire logic        tokenStart,
   input wire logic [3:0]  tokenPid,
   input wire logic [3:0]  tokenEndpoint,
   input wire logic        busResetDrive,
   input wire logic        hostLogicReset,
   input wire logic        eyeTestEnable,
   input wire logic        outputEnableMon_n,
   input wire logic        lowSpeedEop
);
   // ------------------------------------------------
   // request decode and properties
   // ------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire taken = cyc_i && stb_i && !ack_o;
   wire wr    = taken && we_i && sel_i[0];
   wire wrCtl = wr && adr_i == OFF_CONTROL;
   wire wrTok = wr && adr_i == OFF_TOKEN;
   wire wrCfg = wr && adr_i == OFF_CONFIG;
   sequence s_ackPulse; ack_o ##1 !ack_o; endsequence
   sequence s_eop; lowSpeedEop [*2] ##1 !lowSpeedEop; endsequence
   property p_ack; taken |=> s_ackPulse; endproperty
   property p_tok; tokenStart |-> $past(wrTok)
      && tokenPid == $past(dat_i[7:4]) && tokenEndpoint == $past(dat_i[3:0]);
   endproperty
   property p_tokPulse; tokenStart |=> !tokenStart; endproperty
   property p_busRst; wrCtl |-> ##2 busResetDrive == $past(dat_i[4], 2);
   endproperty
   property p_hostRst; hostLogicReset |-> $past(wrCtl) ##1 !hostLogicReset;
   endproperty
   property p_eye; wrCfg |-> ##2 eyeTestEnable == $past(dat_i[7], 2);
   endproperty
   property p_oeMon; !outputEnableMon_n |-> $past(lineDriving); endproperty
   property p_eop; $rose(lowSpeedEop) |-> s_eop; endproperty
   a_ack: assert property (p_ack) else $error("ack not a one cycle answer");
   a_tok: assert property (p_tok) else $error("token outputs wrong");
   a_tokPulse: assert property (p_tokPulse) else $error("start too long");
   a_busRst: assert property (p_busRst) else $error("bus reset wrong");
   a_hostRst: assert property (p_hostRst) else $error("host reset wrong");
   a_eye: assert property (p_eye) else $error("eye test wrong");
   a_oeMon: assert property (p_oeMon) else $error("oe monitor wrong");
   a_eop: assert property (p_eop) else $error("eop length wrong");
endmodule

bind usb_control_token_regs usb_control_token_regs_chk i_chk (
   .core_clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o,
   .lineDriving, .tokenStart, .tokenPid, .tokenEndpoint, .busResetDrive,
   .hostLogicReset, .eyeTestEnable, .outputEnableMon_n, .lowSpeedEop);

/* dv/usb_bus_model.sv */
// Purpose: bus side stand-in for the usb control register block
// Assumes: driven from the bench through its tasks
// Notes:   idle line is a full speed J state
`timescale 1ns/1ns
module usb_bus_model (
   input  wire logic   core_clk,
   input  wire logic   tokenStart,
   output logic        dPlusIn,
   output logic        dMinusIn,
   output logic        setupSeen,
   output logic        sofSeen,
   output logic [10:0] sofFrame,
   output logic        tokenDone,
   output logic        lineDriving
);
   int lag = 6;
   // ------------------------------------------------
   // line levels and token completion
   // ------------------------------------------------
   initial begin
      {dPlusIn, dMinusIn, setupSeen, sofSeen} = 4'h8;
      {tokenDone, lineDriving, sofFrame} = 13'h07FF;
   end
   // finish each started token after lag cycles
   always @(posedge core_clk) begin
      if (tokenStart === 1'b1) begin
         repeat (lag) @(posedge core_clk);
         tokenDone <= 1'b1;
         @(posedge core_clk);
         tokenDone <= 1'b0;
      end
   end
   task automatic lines(input logic p, input logic m);
      @(posedge core_clk);
      {dPlusIn, dMinusIn} <= {p, m};
   endtask
   task automatic drive(input logic d);
      @(posedge core_clk);
      lineDriving <= d;
   endtask
   // frame number only valid beside its pulse
   task automatic sof(input logic [10:0] f);
      @(posedge core_clk);
      {sofSeen, sofFrame} <= {1'b1, f};
      @(posedge core_clk);
      {sofSeen, sofFrame} <= {1'b0, ~f};
   endtask
   task automatic setup;
      @(posedge core_clk);
      setupSeen <= 1'b1;
      @(posedge core_clk);
      setupSeen <= 1'b0;
   endtask
endmodule

/* dv/usb_control_token_regs_tb.sv */
// Purpose: register level test of the usb control register block
// Assumes: wishbone classic slave, bus model answers tokens
// Notes:   line and power outputs are sampled on the falling edge, token outputs and bus reads on the rising edge
`timescale 1ns/1ns
module usb_control_token_regs_tb
   import usb_ctl_pkg::*;
;
   // ------------------------------------------------
   // signals and instances
   // ------------------------------------------------
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic        chipIdle = 1'b0, chipSleep = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, rdData;
   wire  [31:0] dat_o;
   wire  [10:0] sofFrame;
   wire  [3:0]  tokenPid, tokenEndpoint;
   wire         ack_o, dPlusIn, dMinusIn, setupSeen, sofSeen, tokenDone;
   wire         lineDriving, tokenStart, tokenLowSpeed, busResetDrive;
   wire         resumeDrive, lowSpeedEop, hostLogicReset, eyeTestEnable;
   wire         outputEnableMon_n, processingEnable, usbClockStop;
   int          errTotal = 0, checks = 0, n;
   logic [3:0]  pids [3] = '{PID_SETUP, PID_IN, PID_OUT};
   logic [7:0]  offs [6] = '{OFF_ADDRESS, OFF_FRAME_LO, OFF_FRAME_HI,
                             OFF_TOKEN, OFF_CONFIG, 8'h1C};
   always #50 core_clk = ~core_clk;
   usb_control_token_regs i_usb_control_token_regs (.core_clk, .rst, .cyc_i,
      .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .dPlusIn,
      .dMinusIn, .setupSeen, .sofSeen, .sofFrame, .tokenDone, .lineDriving,
      .chipIdle, .chipSleep, .tokenStart, .tokenPid, .tokenEndpoint,
      .tokenLowSpeed, .busResetDrive, .resumeDrive, .lowSpeedEop,
      .hostLogicReset, .eyeTestEnable, .outputEnableMon_n, .processingEnable,
      .usbClockStop);
   usb_bus_model i_usb_bus_model (.core_clk, .tokenStart, .dPlusIn, .dMinusIn,
      .setupSeen, .sofSeen, .sofFrame, .tokenDone, .lineDriving);
   // ------------------------------------------------
   // bus and compare tasks
   // ------------------------------------------------
   task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errTotal++;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic cmpPin(input string s, input logic e, input logic g);
      cmp(s, {31'h0, e}, {31'h0, g});
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
      int k;
      k = 0;
      @(posedge core_clk);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, s};
      do begin
         @(posedge core_clk);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      if (k == 20) errTotal++;
      rdData = dat_o;
      {cyc_i, stb_i} <= 2'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 4'hF);
   endtask
   task automatic chkReg(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      xfer(1'b0, a, 32'h0, 4'hF);
      cmp($sformatf("register %h", a), e, rdData & m);
   endtask
   task automatic settle;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic wrapUp;
      $display("checks %0d mismatches %0d", checks, errTotal);
      if (errTotal == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ------------------------------------------------
   // test sequence and watchdog
   // ------------------------------------------------
   initial begin
      #3000000;
      errTotal++;
      wrapUp;
   end
   initial begin
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      repeat (6) @(posedge core_clk);
      foreach (offs[i]) chkReg(offs[i], 32'hFFFFFFFF, 32'h0);
      chkReg(OFF_CONTROL, 32'hC0, 32'h80);
      i_usb_bus_model.lines(1'b0, 1'b0);
      settle;
      chkReg(OFF_CONTROL, 32'hC0, 32'h40);
      i_usb_bus_model.lines(1'b1, 1'b0);
      wr(OFF_ADDRESS, 32'hFFFFFFFF);
      xfer(1'b1, OFF_ADDRESS, 32'h12, 4'h0);
      chkReg(OFF_ADDRESS, 32'hFFFFFFFF, 32'hFF);
      wr(OFF_FRAME_LO, 32'h55);
      i_usb_bus_model.sof(11'h5A3);
      chkReg(OFF_FRAME_LO, 32'hFFFFFFFF, 32'hA3);
      chkReg(OFF_FRAME_HI, 32'hFFFFFFFF, 32'h05);
      i_usb_bus_model.setup();
      settle;
      cmpPin("processingEnable", 1'b0, processingEnable);
      chkReg(OFF_CONTROL, 32'h20, 32'h20);
      wr(OFF_CONTROL, 32'h0);
      settle;
      cmpPin("processingEnable", 1'b1, processingEnable);
      wr(OFF_CONTROL, 32'h08);
      foreach (pids[i]) begin
         i_usb_bus_model.lag = 6 + 24 * i;
         wr(OFF_ADDRESS, {24'h0, i[0], 7'h12});
         wr(OFF_TOKEN, {24'h0, pids[i], 4'h3 + 4'(i)});
         chkReg(OFF_CONTROL, 32'h28, 32'h28);
         n = 0;
         do begin
            xfer(1'b0, OFF_CONTROL, 32'h0, 4'hF);
            n++;
         end while (rdData[BIT_HOLD] !== 1'b0 && n < 50);
         cmpPin("token busy", 1'b0, rdData[BIT_HOLD]);
         cmp("tokenPid", {28'h0, pids[i]}, {28'h0, tokenPid});
         cmp("tokenEndpoint", 32'h3 + i, {28'h0, tokenEndpoint});
         cmpPin("tokenLowSpeed", i[0], tokenLowSpeed);
      end
      wr(OFF_CONTROL, 32'h18);
      settle;
      cmpPin("busResetDrive", 1'b1, busResetDrive);
      wr(OFF_CONTROL, 32'h0C);
      settle;
      cmpPin("busResetDrive", 1'b0, busResetDrive);
      cmpPin("resumeDrive", 1'b1, resumeDrive);
      wr(OFF_CONTROL, 32'h08);
      n = 0;
      repeat (10) @(negedge core_clk) if (lowSpeedEop === 1'b1) n++;
      cmp("eop cycles", {30'h0, EOP_CYCLES}, n);
      wr(OFF_CONFIG, 32'hFF);
      chkReg(OFF_CONFIG, 32'hFFFFFFFF, 32'hD1);
      i_usb_bus_model.drive(1'b1);
      settle;
      cmpPin("eyeTestEnable", 1'b1, eyeTestEnable);
      cmpPin("outputEnableMon_n", 1'b0, outputEnableMon_n);
      i_usb_bus_model.drive(1'b0);
      @(posedge core_clk) {chipIdle, chipSleep} <= 2'h3;
      settle;
      cmpPin("processingEnable", 1'b0, processingEnable);
      cmpPin("usbClockStop", 1'b1, usbClockStop);
      wr(OFF_CONFIG, 32'h0);
      settle;
      cmpPin("usbClockStop", 1'b0, usbClockStop);
      wr(OFF_SUSPEND, 32'h1);
      settle;
      cmpPin("usbClockStop", 1'b1, usbClockStop);
      wrapUp;
   end
endmodule
